//--- hdl/tahm_monitor.sv
// Alarm, health status and self-test monitor for a T1 service unit
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Summary of operation
// [R1] LOS after 175 consecutive received zeros
// [R2] LOS clears at 12.5 percent ones density
// [R3] Network OOF on two of four framing errors
// [R4] OOF holds until framer reframes
// [R5] AIS while unframed all-ones received
// [R6] ESF error rate above threshold sets flag
// [R7] Yellow flagged per interface on reception
// [R8] Status list ordered by fixed priority
// [R9] Ten-second poll, refresh only on change
// [R10] Five idle minutes selects automatic top view
// [R11] Uncategorised self-test failure keeps eight-digit code
// [R12] Self-test alarm check: AIS send, yellow detect
// [R13] Separate failure per internal loop path
// [R14] Program checksum mismatch reports memory failure
// [R15] Encoder or LOS detector fault combined
// [R16] Master clock failure selects internal clock
// [R17] AIS and yellow clear when signal gone
// [R18] No condition means operational; reset clears flags
// ------------------------------------------------------------------
module tahm_monitor import tahm_pkg::*; #(
  parameter longint POLL_CYCLES = POLL_CYCLES_DEF,
  parameter longint IDLE_CYCLES = IDLE_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [1:0] RX_STB,
  input wire logic [1:0] RX_BIT,
  input wire logic FS_STB,
  input wire logic FS_ERR,
  input wire logic DTE_ALIGN_LOST,
  input wire logic [1:0] REFRAME,
  input wire logic [1:0] UNFRAMED,
  input wire logic [1:0] YEL_RX,
  input wire logic ERR_STB,
  input wire logic MCLK_FAIL,
  input wire logic KEY_ACT,
  input wire logic ST_DONE,
  input wire logic ST_AIS_TX_OK,
  input wire logic ST_YEL_DET_OK,
  input wire logic ST_NET_LOOP_OK,
  input wire logic ST_DTE_LOOP_OK,
  input wire logic ST_DSU_LOOP_OK,
  input wire logic [15:0] ST_CSUM,
  input wire logic [15:0] ST_CSUM_REF,
  input wire logic ST_ENC_OK,
  input wire logic ST_LOSDET_OK,
  input wire logic ST_OTHER_FAIL,
  input wire logic [31:0] ST_FAIL_CODE,
  output logic IRQ,
  output logic AUTO_VIEW,
  output logic [3:0] TOP_CODE,
  output logic INT_CLK_SEL
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic acc;
  logic [31:0] rd_mux;
  logic ctrl_esf;
  logic [EER_W-1:0] eer_thr;
  logic [CODE_W-1:0] list_sel;
  logic [NIRQ-1:0] irq_mask;
  logic [NIRQ-1:0] irq_stat;
  logic [NIRQ-1:0] next_irq_stat;
  logic [NIRQ-1:0] irq_ev;
  logic [1:0] los;
  logic [1:0] ais;
  logic [1:0] oof;
  logic [1:0] yel;
  logic [OOF_WIN-2:0] fs_hist;
  logic net_oof_set;
  logic [EER_WIN_W-1:0] eer_bits;
  logic [EER_W-1:0] eer_errs;
  logic excess_error_rate_flag;
  logic [NST-1:0] st_res;
  logic [31:0] fail_code;
  logic [NFLAG-1:0] live;
  logic [NFLAG-1:0] live_d;
  logic [NFLAG-1:0] report;
  logic [TMR_W-1:0] poll_cnt;
  logic poll_tick;
  logic [TMR_W-1:0] idle_cnt;
  tahm_view_type view;
  tahm_view_type next_view;

  // Nth active condition in priority order, operational when none
  function automatic logic [CODE_W-1:0] nth_code(input logic [NFLAG-1:0] v,
                                                 input logic [CODE_W-1:0] n);
    logic [CODE_W-1:0] seen;
    logic [CODE_W-1:0] code;
    seen = '0;
    code = CODE_OPER;
    for (int k = 0; k < NFLAG; k++) begin
      if (v[k]) begin
        if (seen == n && code == CODE_OPER) begin
          code = CODE_W'(k);
        end
        seen = seen + 1'b1;
      end
    end
    return code;
  endfunction : nth_code

  // Write strobe for one register in the data phase
  function automatic logic wsel(input logic [ADDR_W-1:0] a);
    return wr_pend && (wr_addr == a);
  endfunction : wsel

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign acc = HSEL && HREADY && HTRANS[1];

  // Address phase capture for writes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (CE && HREADY) begin
      wr_pend <= acc && HWRITE;
      wr_addr <= HADDR[ADDR_W-1:0];
    end
  end

  // Read mux, unmapped words read as zero
  always_comb begin
    rd_mux = '0;
    case (HADDR[ADDR_W-1:0])
      A_CTRL: rd_mux[CTRL_ESF] = ctrl_esf;
      A_EER_THR: rd_mux[EER_W-1:0] = eer_thr;
      A_LIVE: rd_mux[NFLAG-1:0] = live;
      A_REPORT: rd_mux[NFLAG-1:0] = report;
      A_LIST_SEL: rd_mux[CODE_W-1:0] = list_sel;
      A_LIST: rd_mux[CODE_W-1:0] = nth_code(report, list_sel);  // R8
      A_IRQ_STAT: rd_mux[NIRQ-1:0] = irq_stat;
      A_IRQ_MASK: rd_mux[NIRQ-1:0] = irq_mask;
      A_SELFTEST: rd_mux[NST-1:0] = st_res;
      A_FAILCODE: rd_mux = fail_code;
      default: rd_mux = '0;
    endcase
  end

  // Zero-wait answer; read data registered at the address phase
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      HRDATA <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else if (CE) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (acc && !HWRITE) begin
        HRDATA <= rd_mux;
      end
    end
  end

  // Software control registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_esf <= 1'b0;
      eer_thr <= EER_THR_RST;
      list_sel <= '0;
      irq_mask <= '0;
    end else if (CE) begin
      if (wsel(A_CTRL)) ctrl_esf <= HWDATA[CTRL_ESF];
      if (wsel(A_EER_THR)) eer_thr <= HWDATA[EER_W-1:0];
      if (wsel(A_LIST_SEL)) list_sel <= HWDATA[CODE_W-1:0];
      if (wsel(A_IRQ_MASK)) irq_mask <= HWDATA[NIRQ-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-interface line conditions, index 0 network, 1 DTE
  // ----------------------------------------------------------------
  assign net_oof_set = FS_STB && ($countones({fs_hist, FS_ERR}) >= OOF_ERRS);  // R3

  // Framing bit error history, last three bits
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      fs_hist <= '0;
    end else if (CE && FS_STB) begin
      fs_hist <= {fs_hist[OOF_WIN-3:0], FS_ERR};
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_if
    logic [ZRUN_W-1:0] zrun;
    logic [WCNT_W-1:0] wcnt;
    logic [ONES_W-1:0] ones;
    logic [ONES_W-1:0] ones_now;
    logic wend;
    logic los_q;
    logic ais_q;
    logic oof_q;
    logic yel_q;
    logic oof_set;

    assign wend = RX_STB[i] && (wcnt == WCNT_W'(DENS_WIN - 1));
    assign ones_now = ones + ONES_W'(RX_BIT[i]);
    assign oof_set = (i == 0) ? net_oof_set : DTE_ALIGN_LOST;

    // Zero run and density window; LOS clear only judged per window
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        zrun <= '0;
        wcnt <= '0;
        ones <= '0;
        los_q <= 1'b0;  // R18
      end else if (CE && RX_STB[i]) begin
        wcnt <= wend ? '0 : wcnt + 1'b1;
        ones <= wend ? '0 : ones_now;
        if (RX_BIT[i]) begin
          zrun <= '0;
        end else if (zrun != ZRUN_W'(LOS_ZEROS)) begin
          zrun <= zrun + 1'b1;
        end
        if (!RX_BIT[i] && zrun == ZRUN_W'(LOS_ZEROS - 1)) begin
          los_q <= 1'b1;  // R1
        end else if (wend && ones_now >= ONES_W'(DENS_MIN)) begin
          los_q <= 1'b0;  // R2
        end
      end
    end

    // AIS needs a whole window of ones; any zero or frame ends it
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        ais_q <= 1'b0;
      end else if (CE) begin
        if (!UNFRAMED[i] || (RX_STB[i] && !RX_BIT[i])) begin
          ais_q <= 1'b0;  // R17
        end else if (wend && ones_now == ONES_W'(DENS_WIN)) begin
          ais_q <= 1'b1;  // R5
        end
      end
    end

    // OOF set wins over a reframe in the same cycle
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        oof_q <= 1'b0;
        yel_q <= 1'b0;
      end else if (CE) begin
        if (oof_set) begin
          oof_q <= 1'b1;
        end else if (REFRAME[i]) begin
          oof_q <= 1'b0;  // R4
        end
        yel_q <= YEL_RX[i];  // R7 R17
      end
    end

    assign los[i] = los_q;
    assign ais[i] = ais_q;
    assign oof[i] = oof_q;
    assign yel[i] = yel_q;
  end

  // ----------------------------------------------------------------
  // Excessive error rate, network side, ESF only
  // ----------------------------------------------------------------
  // Measured over a fixed count of received bits; equal leaves it as is
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      eer_bits <= '0;
      eer_errs <= '0;
      excess_error_rate_flag <= 1'b0;
    end else if (CE) begin
      if (!ctrl_esf) begin
        eer_bits <= '0;
        eer_errs <= '0;
        excess_error_rate_flag <= 1'b0;
      end else if (RX_STB[0] && (&eer_bits)) begin
        eer_bits <= '0;
        eer_errs <= '0;
        if (eer_errs > eer_thr) begin
          excess_error_rate_flag <= 1'b1;  // R6
        end else if (eer_errs < eer_thr) begin
          excess_error_rate_flag <= 1'b0;  // R6
        end
      end else begin
        if (RX_STB[0]) eer_bits <= eer_bits + 1'b1;
        if (ERR_STB && !(&eer_errs)) eer_errs <= eer_errs + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Master clock and self-test results
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      INT_CLK_SEL <= 1'b0;
    end else if (CE) begin
      INT_CLK_SEL <= MCLK_FAIL;  // R16
    end
  end

  // Results captured once per self-test run
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_res <= '0;
      fail_code <= '0;
    end else if (CE && ST_DONE) begin
      st_res[S_DONE] <= 1'b1;
      st_res[S_ALARM] <= !(ST_AIS_TX_OK && ST_YEL_DET_OK);  // R12
      st_res[S_NET] <= !ST_NET_LOOP_OK;  // R13
      st_res[S_DTE] <= !ST_DTE_LOOP_OK;  // R13
      st_res[S_DSU] <= !ST_DSU_LOOP_OK;  // R13
      st_res[S_MEM] <= (ST_CSUM != ST_CSUM_REF);  // R14
      st_res[S_ENC] <= !(ST_ENC_OK && ST_LOSDET_OK);  // R15
      st_res[S_OTHER] <= ST_OTHER_FAIL;
      fail_code <= ST_OTHER_FAIL ? ST_FAIL_CODE : '0;  // R11
    end
  end

  // ----------------------------------------------------------------
  // Status collection and periodic report
  // ----------------------------------------------------------------
  always_comb begin
    live = '0;
    live[F_LOS_NET] = los[0];
    live[F_LOS_DTE] = los[1];
    live[F_OOF_NET] = oof[0];
    live[F_OOF_DTE] = oof[1];
    live[F_AIS_NET] = ais[0];
    live[F_AIS_DTE] = ais[1];
    live[F_EER] = excess_error_rate_flag;
    live[F_YEL_NET] = yel[0];
    live[F_YEL_DTE] = yel[1];
    live[F_ST] = |st_res[S_ENC:S_ALARM];
    live[F_DEVF] = st_res[S_OTHER];
    live[F_MCLK] = INT_CLK_SEL;
  end

  assign poll_tick = (poll_cnt == TMR_W'(POLL_CYCLES - 1));

  // Poll timer; report and top entry move only when status changed
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      poll_cnt <= '0;
      report <= '0;
      TOP_CODE <= CODE_OPER;  // R18
    end else if (CE) begin
      poll_cnt <= poll_tick ? '0 : poll_cnt + 1'b1;
      if (poll_tick && live != report) begin
        report <= live;  // R9
        TOP_CODE <= nth_code(live, '0);  // R8 R9
      end
    end
  end

  // ----------------------------------------------------------------
  // View selection on keypad idle
  // ----------------------------------------------------------------
  always_comb begin
    case (view)
      VIEW_MENU: next_view = (idle_cnt == TMR_W'(IDLE_CYCLES - 1)) ? VIEW_AUTO : VIEW_MENU;
      VIEW_AUTO: next_view = KEY_ACT ? VIEW_MENU : VIEW_AUTO;
      default: next_view = VIEW_MENU;
    endcase
    if (KEY_ACT) next_view = VIEW_MENU;
  end

  // Idle timer restarts on any key
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      idle_cnt <= '0;
      view <= VIEW_MENU;
      AUTO_VIEW <= 1'b0;
    end else if (CE) begin
      if (KEY_ACT || view == VIEW_AUTO) begin
        idle_cnt <= '0;
      end else begin
        idle_cnt <= idle_cnt + 1'b1;
      end
      view <= next_view;
      AUTO_VIEW <= (next_view == VIEW_AUTO);  // R10
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_ev = '0;
    irq_ev[NFLAG-1:0] = live & ~live_d;
    irq_ev[IRQ_CHG] = poll_tick && live != report;
    irq_ev[IRQ_STDONE] = ST_DONE;
    next_irq_stat = irq_stat;
    if (wsel(A_IRQ_STAT)) next_irq_stat = irq_stat & ~HWDATA[NIRQ-1:0];
    next_irq_stat = next_irq_stat | irq_ev;  // New event beats the clear
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      live_d <= '0;
      irq_stat <= '0;
      IRQ <= 1'b0;
    end else if (CE) begin
      live_d <= live;
      irq_stat <= next_irq_stat;
      IRQ <= |(irq_stat & irq_mask);
    end
  end

endmodule : tahm_monitor

//--- hdl/tahm_pkg.sv
// Constants and types shared by the T1 alarm and health monitor
package tahm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 40000000;
  localparam longint POLL_TIME_S = 10;
  localparam longint IDLE_TIME_S = 300;  // five minutes
  localparam longint POLL_CYCLES_DEF = POLL_TIME_S * CLK_HZ;
  localparam longint IDLE_CYCLES_DEF = IDLE_TIME_S * CLK_HZ;
  localparam int TMR_W = 34;

  // ----------------------------------------------------------------
  // Line criteria
  // ----------------------------------------------------------------
  localparam int LOS_ZEROS = 175;
  localparam int ZRUN_W = 8;
  localparam int DENS_WIN = 32;
  localparam int DENS_PERMILLE = 125;  // 12.5 percent
  localparam int DENS_MIN = (DENS_WIN * DENS_PERMILLE + 999) / 1000;
  localparam int WCNT_W = 5;
  localparam int ONES_W = 6;
  localparam int OOF_WIN = 4;
  localparam int OOF_ERRS = 2;
  localparam int EER_WIN_W = 16;
  localparam int EER_W = 16;
  localparam logic [EER_W-1:0] EER_THR_RST = 16'h0010;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_EER_THR = 8'h04;
  localparam logic [ADDR_W-1:0] A_LIVE = 8'h08;
  localparam logic [ADDR_W-1:0] A_REPORT = 8'h0c;
  localparam logic [ADDR_W-1:0] A_LIST_SEL = 8'h10;
  localparam logic [ADDR_W-1:0] A_LIST = 8'h14;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h1c;
  localparam logic [ADDR_W-1:0] A_SELFTEST = 8'h20;
  localparam logic [ADDR_W-1:0] A_FAILCODE = 8'h24;
  localparam int CTRL_ESF = 0;

  // ----------------------------------------------------------------
  // Condition flags, highest priority at bit 0
  // ----------------------------------------------------------------
  localparam int F_LOS_NET = 0;
  localparam int F_LOS_DTE = 1;
  localparam int F_OOF_NET = 2;
  localparam int F_OOF_DTE = 3;
  localparam int F_AIS_NET = 4;
  localparam int F_AIS_DTE = 5;
  localparam int F_EER = 6;
  localparam int F_YEL_NET = 7;
  localparam int F_YEL_DTE = 8;
  localparam int F_ST = 9;
  localparam int F_DEVF = 10;
  localparam int F_MCLK = 11;
  localparam int NFLAG = 12;
  localparam int IRQ_CHG = 12;
  localparam int IRQ_STDONE = 13;
  localparam int NIRQ = 14;
  localparam int CODE_W = 4;
  localparam logic [CODE_W-1:0] CODE_OPER = 4'hf;

  // Self-test result bits
  localparam int S_DONE = 0;
  localparam int S_ALARM = 1;
  localparam int S_NET = 2;
  localparam int S_DTE = 3;
  localparam int S_DSU = 4;
  localparam int S_MEM = 5;
  localparam int S_ENC = 6;
  localparam int S_OTHER = 7;
  localparam int NST = 8;

  typedef enum logic [1:0] {VIEW_MENU = 2'b01, VIEW_AUTO = 2'b10} tahm_view_type;
endpackage : tahm_pkg

//--- verification/tahm_monitor_properties.sv
// Port-level checker for the alarm and health monitor
`timescale 1ns/10ps
module tahm_monitor_chk #(
  parameter longint POLL_CYCLES = 100,
  parameter longint IDLE_CYCLES = 300
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic MCLK_FAIL,
  input wire logic KEY_ACT,
  input wire logic AUTO_VIEW,
  input wire logic [3:0] TOP_CODE,
  input wire logic INT_CLK_SEL
);
  longint idle_cnt;
  longint since_chg;
  logic [3:0] prev_code;
  logic rd_taken;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // ------------
  // Helper counters
  // ------------
  // Idle time and report spacing
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      idle_cnt <= 0;
      since_chg <= 0;
      prev_code <= 4'hf;
      rd_taken <= 1'b0;
    end else begin
      idle_cnt <= KEY_ACT ? 64'd0 : idle_cnt + 1;
      since_chg <= (TOP_CODE != prev_code) ? 64'd1 : since_chg + 1;
      prev_code <= TOP_CODE;
      rd_taken <= HSEL && HREADY && HTRANS[1] && !HWRITE && CE;
    end
  end

  // ------------
  // Assertions
  // ------------
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus wait or error");
  read_hold_a: assert property (!rd_taken |-> $stable(HRDATA))
    else $error("read data moved");
  clk_fallback_a: assert property ($rose(MCLK_FAIL) |=> INT_CLK_SEL)
    else $error("no internal clock");
  clk_restore_a: assert property ($fell(MCLK_FAIL) |=> !INT_CLK_SEL)
    else $error("internal clock kept");
  key_exit_a: assert property (KEY_ACT |=> !AUTO_VIEW)
    else $error("auto view kept");
  idle_early_a: assert property ($rose(AUTO_VIEW) |-> idle_cnt >= IDLE_CYCLES - 2)
    else $error("auto view early");
  idle_late_a: assert property (idle_cnt > IDLE_CYCLES + 2 |-> AUTO_VIEW)
    else $error("auto view late");
  poll_spacing_a: assert property (TOP_CODE != prev_code |-> since_chg >= POLL_CYCLES - 2)
    else $error("report refreshed between polls");
  code_range_a: assert property (TOP_CODE < 4'hc || TOP_CODE == 4'hf)
    else $error("top code out of range");
endmodule : tahm_monitor_chk

bind tahm_monitor tahm_monitor_chk #(.POLL_CYCLES(POLL_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)) chk_u (
  .CLK, .RESETN, .CE, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
  .MCLK_FAIL, .KEY_ACT, .AUTO_VIEW, .TOP_CODE, .INT_CLK_SEL);

//--- verification/tahm_line_model.sv
// Behavioural T1 line and DSX-1 equipment feeding the monitor
`timescale 1ns/10ps
module tahm_line_model (
  input wire logic clk,
  output logic [1:0] rx_stb,
  output logic [1:0] rx_bit,
  output logic fs_stb,
  output logic fs_err,
  output logic align_lost,
  output logic [1:0] reframe,
  output logic [1:0] unframed,
  output logic [1:0] yel_rx,
  output logic err_stb
);
  logic [3:0] ev;

  // Event pulses: reframe net/dte, alignment lost, bit error
  assign reframe = ev[1:0];
  assign align_lost = ev[2];
  assign err_stb = ev[3];

  // Quiet line at time zero
  initial begin
    rx_stb = 2'b00;
    rx_bit = 2'b00;
    fs_stb = 1'b0;
    fs_err = 1'b0;
    ev = 4'h0;
    unframed = 2'b00;
    yel_rx = 2'b00;
  end

  // ------------
  // Stimulus tasks
  // ------------
  // One bit per clock; a one every per bits, per 0 gives all zeros
  // Released line shows the inverse
  task automatic send(input int p, input int n, input int per);
    logic b = 1'b0;
    for (int i = 0; i < n; i++) begin
      b = (per != 0) && (i % per == 0);
      @(posedge clk);
      rx_stb[p] <= 1'b1;
      rx_bit[p] <= b;
    end
    @(posedge clk);
    rx_stb[p] <= 1'b0;
    rx_bit[p] <= ~b;
  endtask : send

  // One framing bit, good or in error
  task automatic frame(input logic err);
    @(posedge clk);
    fs_stb <= 1'b1;
    fs_err <= err;
    @(posedge clk);
    fs_stb <= 1'b0;
    fs_err <= ~err;
  endtask : frame

  // Spaced single-cycle pulses of one event
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev[k] <= 1'b0;
    end
  endtask : pulse

  // Framing state and received yellow, held as levels
  task automatic set_lines(input logic [1:0] unf, input logic [1:0] yel);
    @(posedge clk);
    unframed <= unf;
    yel_rx <= yel;
  endtask : set_lines
endmodule : tahm_line_model

//--- verification/tb_t1_alarm_health_monitor.sv
// Self-checking bench for the T1 alarm and health monitor
`timescale 1ns/10ps
module tb_t1_alarm_health_monitor import tahm_pkg::*;;
  localparam longint POLL = 100;
  localparam longint IDLE = 300;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, st_done, mclk_fail, key_act, ce;
  logic irq, auto_view, int_clk_sel, fs_stb, fs_err, align_lost, err_stb;
  logic [1:0] htrans, rx_stb, rx_bit, reframe, unframed, yel_rx;
  logic [2:0] hsize;
  logic [3:0] top_code;
  logic [8:0] fm;
  logic [31:0] haddr, hwdata, hrdata, rd, fail_code;
  int num_errors, checks;
  // Self-test rows: fault bits, expected result byte
  logic [16:0] rows [10] = '{17'h00103, 17'h00203, 17'h00405, 17'h00809, 17'h01011,
    17'h02041, 17'h04041, 17'h08021, 17'h10081, 17'h00001};

  tahm_monitor #(.POLL_CYCLES(POLL), .IDLE_CYCLES(IDLE)) dut_u (
    .CLK(clk), .RESETN(resetn), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .RX_STB(rx_stb), .RX_BIT(rx_bit), .FS_STB(fs_stb),
    .FS_ERR(fs_err), .DTE_ALIGN_LOST(align_lost), .REFRAME(reframe), .UNFRAMED(unframed),
    .YEL_RX(yel_rx), .ERR_STB(err_stb), .MCLK_FAIL(mclk_fail), .KEY_ACT(key_act),
    .ST_DONE(st_done), .ST_AIS_TX_OK(!fm[0]), .ST_YEL_DET_OK(!fm[1]), .ST_NET_LOOP_OK(!fm[2]),
    .ST_DTE_LOOP_OK(!fm[3]), .ST_DSU_LOOP_OK(!fm[4]), .ST_ENC_OK(!fm[5]), .ST_LOSDET_OK(!fm[6]),
    .ST_CSUM(16'h5a5a), .ST_CSUM_REF({15'h2d2d, fm[7]}), .ST_OTHER_FAIL(fm[8]),
    .ST_FAIL_CODE(fail_code), .IRQ(irq), .AUTO_VIEW(auto_view), .TOP_CODE(top_code),
    .INT_CLK_SEL(int_clk_sel));

  tahm_line_model line_u (.clk(clk), .rx_stb(rx_stb), .rx_bit(rx_bit), .fs_stb(fs_stb),
    .fs_err(fs_err), .align_lost(align_lost), .reframe(reframe), .unframed(unframed),
    .yel_rx(yel_rx), .err_stb(err_stb));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ------------
  // Helpers
  // ------------
  task automatic results();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Bounded wait for hready; a hang ends the run
  task automatic rdy();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      results();
    end
  endtask : rdy

  // Single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask : bus

  // Settle, then read and compare
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    cyc(2);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  // Wait for the auto view (sel 1) or a top code (sel 0)
  task automatic wait_sig(input logic sel, input logic [3:0] v);
    int n = 0;
    while ((sel ? {3'h0, auto_view} : top_code) !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(32'(sel ? {3'h0, auto_view} : top_code), 32'(v));
    if (n >= 400) results();
  endtask : wait_sig

  // ------------
  // Main sequence
  // ------------
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    st_done = 1'b0;
    mclk_fail = 1'b0;
    key_act = 1'b0;
    fm = 9'h0;
    fail_code = 32'h0;
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(32'({irq, auto_view, int_clk_sel, top_code}), 32'hf);
    rchk(A_LIVE, 32'h0);
    rchk(A_EER_THR, 32'h10);
    bus(1'b1, 8'h40, 32'hffffffff);
    rchk(8'h40, 32'h0);
    // LOS: one zero short, the 175th, then density recovery
    for (int p = 0; p < 2; p++) begin
      line_u.send(p, 174, 0);
      rchk(A_LIVE, 32'h0);
      line_u.send(p, 1, 0);
      rchk(A_LIVE, 32'(1 << p));
      line_u.send(p, 64, 8);
      rchk(A_LIVE, 32'h0);
    end
    // Unframed all ones, then each cause removed
    line_u.set_lines(2'b11, 2'b00);
    for (int p = 0; p < 2; p++) begin
      line_u.send(p, 64, 1);
      rchk(A_LIVE, p ? 32'h30 : 32'h10);
    end
    line_u.send(0, 1, 0);
    rchk(A_LIVE, 32'h20);
    line_u.set_lines(2'b00, 2'b00);
    rchk(A_LIVE, 32'h0);
    // One framing error in four tolerated, two not
    line_u.frame(1'b1);
    line_u.frame(1'b0);
    line_u.frame(1'b0);
    rchk(A_LIVE, 32'h0);
    line_u.frame(1'b1);
    rchk(A_LIVE, 32'h4);
    line_u.pulse(0, 1);
    rchk(A_LIVE, 32'h0);
    line_u.pulse(2, 1);
    rchk(A_LIVE, 32'h8);
    line_u.pulse(1, 1);
    rchk(A_LIVE, 32'h0);
    // CE low freezes every flop
    ce <= 1'b0;
    line_u.pulse(2, 1);
    ce <= 1'b1;
    rchk(A_LIVE, 32'h0);
    line_u.set_lines(2'b00, 2'b11);
    rchk(A_LIVE, 32'h180);
    line_u.set_lines(2'b00, 2'b00);
    rchk(A_LIVE, 32'h0);
    // Three errors over a threshold of two in one window
    bus(1'b1, A_CTRL, 32'h1);
    bus(1'b1, A_EER_THR, 32'h2);
    rchk(A_EER_THR, 32'h2);
    line_u.pulse(3, 3);
    line_u.send(0, 65536, 1);
    rchk(A_LIVE, 32'h40);
    bus(1'b1, A_CTRL, 32'h0);
    rchk(A_LIVE, 32'h0);
    // Self-test outcomes, one fault at a time
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      fm <= rows[i][16:8];
      fail_code <= rows[i][16] ? 32'h13579bdf : 32'h0;
      st_done <= 1'b1;
      @(posedge clk);
      st_done <= 1'b0;
      rchk(A_SELFTEST, 32'(rows[i][7:0]));
      if (rows[i][16]) rchk(A_FAILCODE, 32'h13579bdf);
    end
    // Key press leaves auto view until idle time runs out
    @(posedge clk);
    key_act <= 1'b1;
    @(posedge clk);
    key_act <= 1'b0;
    cyc(1);
    chk(32'(auto_view), 32'h0);
    cyc(int'(IDLE) - 20);
    chk(32'(auto_view), 32'h0);
    wait_sig(1'b1, 4'h1);
    // Poll report, priority list and the change interrupt
    bus(1'b1, A_IRQ_STAT, 32'h3fff);
    bus(1'b1, A_IRQ_MASK, 32'h1000);
    @(posedge clk);
    mclk_fail <= 1'b1;
    line_u.set_lines(2'b00, 2'b01);
    wait_sig(1'b0, 4'h7);
    chk(32'(int_clk_sel), 32'h1);
    rchk(A_REPORT, 32'h880);
    bus(1'b1, A_LIST_SEL, 32'h1);
    rchk(A_LIST, 32'hb);
    rchk(A_IRQ_STAT, 32'h1880);
    chk(32'(irq), 32'h1);
    bus(1'b1, A_IRQ_MASK, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    bus(1'b1, A_IRQ_STAT, 32'h1000);
    bus(1'b1, A_IRQ_MASK, 32'h1000);
    rchk(A_IRQ_MASK, 32'h1000);
    cyc(int'(POLL) + 20);
    rchk(A_IRQ_STAT, 32'h880);
    chk(32'(irq), 32'h0);
    @(posedge clk);
    mclk_fail <= 1'b0;
    line_u.set_lines(2'b00, 2'b00);
    wait_sig(1'b0, 4'hf);
    chk(32'(int_clk_sel), 32'h0);
    results();
  end
endmodule : tb_t1_alarm_health_monitor
